// ==== prom_pkg.sv ====
// Shared constants for the registered PROM readout block.
package prom_pkg;
   // ---------------------------------------------------------------
   // Array geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int WORDS  = 2048;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;
   localparam int SYNC_PULSE_MS  = 10;
   localparam int SYNC_PULSE_CYC = SYNC_PULSE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int PULSE_CNT_W    = 20;

   // ---------------------------------------------------------------
   // Delivered contents
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] ERASED_WORD    = 8'h00;
   localparam logic              SYNC_CELL_INIT = 1'b0;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int                PADDR_W     = 12;
   localparam logic [11:0]       CTRL_OFS    = 12'h000;
   localparam logic [11:0]       STATUS_OFS  = 12'h004;
   localparam logic              CTRL_RESET  = 1'b1;
   localparam int                CTRL_ALLOW  = 0;
   localparam int                ST_SYNC     = 0;
   localparam int                ST_KNOWN    = 1;
   localparam int                ST_OE       = 2;
   localparam int                ST_PROG     = 3;
   localparam int                ST_INIT_LSB = 8;
endpackage : prom_pkg

// ==== prom_array.sv ====
// Nonvolatile storage: main array, initialization word and enable-mode cell.
`timescale 1ns/1ps
module prom_array #(
   parameter int ADDR_W = 11,
   parameter int DATA_W = 8,
   parameter int WORDS  = 2048
) (
   input  wire logic              clk,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic      [DATA_W-1:0] rd_data,
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              init_wr,
   output logic      [DATA_W-1:0] init_word,
   input  wire logic              cell_wr,
   output logic                   sync_cell
);
   initial begin
      if (WORDS > (1 << ADDR_W)) $error("prom_array: WORDS exceeds address space");
   end

   logic [DATA_W-1:0] mem [WORDS];

   // Delivered state: every word and cell erased. The storage is not touched by
   // the system reset, since it models cells that survive power cycles.
   initial begin
      for (int i = 0; i < WORDS; i++) begin
         mem[i] = prom_pkg::ERASED_WORD;
      end
      init_word = prom_pkg::ERASED_WORD;
      sync_cell = prom_pkg::SYNC_CELL_INIT;
      rd_data   = prom_pkg::ERASED_WORD;
   end

   // Programming can only set bits, never clear them. A plain clocked process
   // is used because the delivered contents are also set at time zero above.
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= mem[wr_addr] | wr_data;
      end
      if (init_wr) begin
         init_word <= init_word | wr_data;
      end
      if (cell_wr) begin
         sync_cell <= 1'b1;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : prom_array

// ==== prom_apb_regs.sv ====
// APB slave with the control and status registers of the PROM block.
`timescale 1ns/1ps
module prom_apb_regs (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [31:0] status,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             prog_allow
);
   typedef struct packed {
      logic        allow;
      logic [31:0] rdata;
   } regs_s;

   regs_s cur;
   regs_s next_cur;
   logic  mapped;

   assign mapped     = (paddr == prom_pkg::CTRL_OFS) || (paddr == prom_pkg::STATUS_OFS);
   assign pready     = 1'b1;
   assign pslverr    = psel && penable && !mapped;
   assign prdata     = cur.rdata;
   assign prog_allow = cur.allow;

   // Read data is captured in the setup cycle so it stands from a flop.
   always_comb begin
      next_cur = cur;
      if (psel && !penable && !pwrite) begin
         if (paddr == prom_pkg::CTRL_OFS) begin
            next_cur.rdata = {31'h0, cur.allow};
         end else if (paddr == prom_pkg::STATUS_OFS) begin
            next_cur.rdata = status;
         end else begin
            next_cur.rdata = 32'h0;
         end
      end
      if (psel && penable && pwrite && paddr == prom_pkg::CTRL_OFS) begin
         next_cur.allow = pwdata[prom_pkg::CTRL_ALLOW];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '{allow: prom_pkg::CTRL_RESET, rdata: 32'h0};
      end else begin
         cur <= next_cur;
      end
   end
endmodule : prom_apb_regs

// ==== registered_prom_readout.sv ====
// Registered 2048 x 8 PROM with output enable modes, initialize word and programming.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module registered_prom_readout #(
   parameter int SYNC_PULSE_CYCLES = prom_pkg::SYNC_PULSE_CYC
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic [prom_pkg::ADDR_W-1:0] word_address,
   input  wire logic                        clock_program_strobe,
   input  wire logic                        verify_strobe_n,
   input  wire logic                        init_n,
   input  wire logic                        program_voltage,
   input  wire logic                        a1_super_voltage,
   input  wire logic [prom_pkg::DATA_W-1:0] word_outputs_in,
   output logic      [prom_pkg::DATA_W-1:0] word_outputs_out,
   output logic                             word_outputs_oe,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [11:0]                 paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr
);
   localparam logic [prom_pkg::PULSE_CNT_W-1:0] PULSE_LAST =
      prom_pkg::PULSE_CNT_W'(SYNC_PULSE_CYCLES - 1);

   initial begin
      if (SYNC_PULSE_CYCLES < 1 || SYNC_PULSE_CYCLES >= (1 << prom_pkg::PULSE_CNT_W)) begin
         $error("registered_prom_readout: SYNC_PULSE_CYCLES out of range");
      end
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                            mode_known;
      logic                            sync_mode;
      logic                            oe_sync;
      logic                            hold_init;
      logic                            strobe_q;
      logic [prom_pkg::PULSE_CNT_W-1:0] pulse_cnt;
   } state_s;

   state_s cur;
   state_s next_cur;

   logic [prom_pkg::DATA_W-1:0] mem_q;
   logic [prom_pkg::DATA_W-1:0] init_word;
   logic                        sync_cell;
   logic                        prog_allow;
   logic                        init_active;
   logic                        strobe_fall;
   logic                        pgm_ok;
   logic                        byte_wr;
   logic                        init_wr;
   logic                        cell_pulse;
   logic                        cell_wr;
   logic                        read_oe;
   logic                        verify_oe;
   logic [31:0]                 status;

   // ---------------------------------------------------------------
   // Programming decode
   // ---------------------------------------------------------------
   assign init_active = !init_n && !program_voltage;
   assign strobe_fall = cur.strobe_q && !clock_program_strobe;
   // A write needs programming voltage, prog_allow set, strobe low and verify high.
   assign pgm_ok      = program_voltage && prog_allow && verify_strobe_n;
   assign byte_wr     = pgm_ok && strobe_fall && !a1_super_voltage;
   // Super voltage on bit 1 with bit 2 low reaches the initialization word.
   assign init_wr     = pgm_ok && strobe_fall && a1_super_voltage && !word_address[2];
   assign cell_pulse  = pgm_ok && !clock_program_strobe && a1_super_voltage && word_address[2];
   // The enable cell commits only after a full-length strobe pulse.
   assign cell_wr     = cell_pulse && (cur.pulse_cnt == PULSE_LAST);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // The registered read of the array is the output stage, loaded on every
   // pclk edge from the address held before it.
   prom_array #(
      .ADDR_W (prom_pkg::ADDR_W),
      .DATA_W (prom_pkg::DATA_W),
      .WORDS  (prom_pkg::WORDS)
   ) u_array (
      .clk       (pclk),
      .rd_addr   (word_address),
      .rd_data   (mem_q),
      .wr_en     (byte_wr),
      .wr_addr   (word_address),
      .wr_data   (word_outputs_in),
      .init_wr   (init_wr),
      .init_word (init_word),
      .cell_wr   (cell_wr),
      .sync_cell (sync_cell)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_cur          = cur;
      next_cur.strobe_q = clock_program_strobe;
      // The mode cell is sampled once after reset and then frozen, so a cell
      // programmed later only takes effect after the next presetn reset.
      if (!cur.mode_known) begin
         next_cur.mode_known = 1'b1;
         next_cur.sync_mode  = sync_cell;
      end
      // Synchronous enable is taken at each edge.
      next_cur.oe_sync   = !verify_strobe_n;
      // The preset word stays until the first edge that sees preset high.
      next_cur.hold_init = init_active;
      if (cell_pulse) begin
         if (cur.pulse_cnt < PULSE_LAST + 1'b1) begin
            next_cur.pulse_cnt = cur.pulse_cnt + 1'b1;
         end
      end else begin
         next_cur.pulse_cnt = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '{mode_known: 1'b0, sync_mode: 1'b0, oe_sync: 1'b0, hold_init: 1'b0,
                  strobe_q: 1'b0, pulse_cnt: '0};
      end else begin
         cur <= next_cur;
      end
   end

   // ---------------------------------------------------------------
   // Output pins
   // ---------------------------------------------------------------
   // Preset overrides the output stage at once, before any clock edge.
   assign word_outputs_out = (init_active || cur.hold_init) ? init_word : mem_q;

   // Read-mode outputs stay off until the mode cell has been read, so neither mode can
   // glitch the bus in the first cycle after reset.
   assign read_oe   = cur.mode_known && (cur.sync_mode ? cur.oe_sync : !verify_strobe_n);
   assign verify_oe = clock_program_strobe && !verify_strobe_n;
   // Asynchronous enable acts without the clock.
   assign word_outputs_oe = program_voltage ? verify_oe : read_oe;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   assign status = {16'h0, init_word, 4'h0, program_voltage, word_outputs_oe,
                    cur.mode_known, cur.sync_mode};

   prom_apb_regs u_regs (
      .pclk       (pclk),
      .presetn    (presetn),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .paddr      (paddr),
      .pwdata     (pwdata),
      .status     (status),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .prog_allow (prog_allow)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_sync_powerup_off: assert property ($rose(cur.mode_known) && cur.sync_mode
      |-> !word_outputs_oe) else $error("sync mode drove outputs at power-up");
   chk_async_enable_follow: assert property (cur.mode_known && !cur.sync_mode && !program_voltage
      |-> word_outputs_oe == !verify_strobe_n) else $error("async enable not followed");
   chk_sync_off_edge: assert property (cur.mode_known && cur.sync_mode && verify_strobe_n
      ##1 !program_voltage |-> !word_outputs_oe) else $error("sync disable missed");
   chk_sync_on_edge: assert property (cur.mode_known && cur.sync_mode && !verify_strobe_n
      ##1 !program_voltage |-> word_outputs_oe) else $error("sync enable missed");
   chk_sync_between_edges: assert property (cur.mode_known && cur.sync_mode && !program_voltage
      |-> word_outputs_oe == $past(!verify_strobe_n)) else $error("sync enable moved");
   chk_preset_immediate: assert property (init_active
      |-> word_outputs_out == init_word) else $error("preset word not shown");
   chk_preset_hold: assert property (init_active ##1 init_n
      |-> word_outputs_out == $past(init_word)) else $error("preset word lost at edge");
   chk_read_latency: assert property (init_n && !cur.hold_init ##1 init_n && !cur.hold_init
      |-> word_outputs_out == mem_q) else $error("output stage not from array");
   chk_mode_frozen: assert property (cur.mode_known
      |=> $stable(cur.sync_mode)) else $error("enable mode changed after power-up");
   chk_verify_drive: assert property (program_voltage && verify_strobe_n
      |-> !word_outputs_oe) else $error("outputs driven while programming");
   chk_cell_pulse_len: assert property (cell_wr
      |-> $past(cell_pulse) && cur.pulse_cnt == PULSE_LAST) else $error("short cell pulse");

   cov_sync_read: cover property (cur.sync_mode && word_outputs_oe && !program_voltage);
   cov_preset: cover property (init_active ##1 init_n ##1 word_outputs_oe);
   cov_byte_program: cover property (byte_wr ##[1:20] verify_oe);
   cov_cell_program: cover property (cell_wr);
endmodule : registered_prom_readout

// ==== prom_programmer_model.sv ====
// Behavioural sequencer and device programmer that drives the PROM pins.
`timescale 1ns/1ps
module prom_programmer_model (
   input  wire logic        pclk,
   input  wire logic [7:0]  dev_out,
   input  wire logic        dev_oe,
   output logic      [10:0] word_address,
   output logic             clock_program_strobe,
   output logic             verify_strobe_n,
   output logic             init_n,
   output logic             program_voltage,
   output logic             a1_super_voltage,
   output logic      [7:0]  data_pins
);
   logic [7:0] mdl_data;
   logic       mdl_drive;
   // A floating bus shows the inverse of the last byte, so stale data never passes.
   assign data_pins = mdl_drive ? mdl_data : (dev_oe ? dev_out : ~mdl_data);
   initial begin
      word_address = 11'h000;
      clock_program_strobe = 1'b1;
      verify_strobe_n = 1'b1;
      init_n = 1'b1;
      program_voltage = 1'b0;
      a1_super_voltage = 1'b0;
      mdl_data = 8'h00;
      mdl_drive = 1'b0;
   end
   task automatic set_addr(input logic [10:0] a);
      @(posedge pclk);
      word_address <= a;
   endtask : set_addr
   task automatic set_verify(input logic v);
      @(posedge pclk);
      verify_strobe_n <= v;
   endtask : set_verify
   task automatic set_init(input logic v);
      @(posedge pclk);
      init_n <= v;
   endtask : set_init
   task automatic enter_prog();
      @(posedge pclk);
      clock_program_strobe <= 1'b1;
      verify_strobe_n <= 1'b1;
      init_n <= 1'b1;
      @(posedge pclk);
      program_voltage <= 1'b1;
   endtask : enter_prog
   task automatic exit_prog();
      @(posedge pclk);
      program_voltage <= 1'b0;
   endtask : exit_prog
   // One byte at a time: address and data settle before the strobe falls.
   task automatic pulse(input logic [10:0] a, input logic sv, input logic [7:0] d, input int len);
      @(posedge pclk);
      word_address <= a;
      a1_super_voltage <= sv;
      mdl_data <= d;
      mdl_drive <= 1'b1;
      @(posedge pclk);
      clock_program_strobe <= 1'b0;
      repeat (len) @(posedge pclk);
      clock_program_strobe <= 1'b1;
      repeat (2) @(posedge pclk);
      mdl_drive <= 1'b0;
      a1_super_voltage <= 1'b0;
   endtask : pulse
endmodule : prom_programmer_model

// ==== registered_prom_readout_bench.sv ====
// Self-checking bench for the registered PROM readout block.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %0t got %h want %h", $time, g, e); end end
module registered_prom_readout_bench;
   localparam int CELL_LEN = 8;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, dev_oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [10:0] word_address;
   logic        clock_program_strobe, verify_strobe_n, init_n, program_voltage, a1_super_voltage;
   logic [7:0]  data_pins, dev_out;
   int          n_errors = 0;
   int          checks_done = 0;
   registered_prom_readout #(.SYNC_PULSE_CYCLES(CELL_LEN)) registered_prom_readout_inst (
      .pclk                 (pclk),
      .presetn              (presetn),
      .word_address         (word_address),
      .clock_program_strobe (clock_program_strobe),
      .verify_strobe_n      (verify_strobe_n),
      .init_n               (init_n),
      .program_voltage      (program_voltage),
      .a1_super_voltage     (a1_super_voltage),
      .word_outputs_in      (data_pins),
      .word_outputs_out     (dev_out),
      .word_outputs_oe      (dev_oe),
      .psel                 (psel),
      .penable              (penable),
      .pwrite               (pwrite),
      .paddr                (paddr),
      .pwdata               (pwdata),
      .prdata               (prdata),
      .pready               (pready),
      .pslverr              (pslverr)
   );
   prom_programmer_model prom_programmer_model_inst (
      .pclk                 (pclk),
      .dev_out              (dev_out),
      .dev_oe               (dev_oe),
      .word_address         (word_address),
      .clock_program_strobe (clock_program_strobe),
      .verify_strobe_n      (verify_strobe_n),
      .init_n               (init_n),
      .program_voltage      (program_voltage),
      .a1_super_voltage     (a1_super_voltage),
      .data_pins            (data_pins)
   );
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;
   // ---------------------------------------------------------------
   // Bus and pin helpers
   // ---------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick
   task automatic look();
      @(negedge pclk);
   endtask : look
   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      tick(12);
      presetn <= 1'b1;
   endtask : do_reset
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int guard;
      guard = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         guard++;
      end while (pready !== 1'b1 && guard < 50);
      if (guard >= 50) n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk_verify(input logic [7:0] e);
      prom_programmer_model_inst.set_verify(1'b0);
      look();
      `CHK(dev_oe, 1'b1)
      `CHK(data_pins, e)
      prom_programmer_model_inst.set_verify(1'b1);
   endtask : chk_verify
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_blank();
      logic [31:0] rd;
      logic        err;
      apb(1'b0, prom_pkg::STATUS_OFS, 32'h0, rd, err);
      `CHK(rd[prom_pkg::ST_SYNC], 1'b0)
      `CHK(rd[15:8], prom_pkg::ERASED_WORD)
      apb(1'b0, prom_pkg::CTRL_OFS, 32'h0, rd, err);
      `CHK(rd[prom_pkg::CTRL_ALLOW], prom_pkg::CTRL_RESET)
      look();
      `CHK(dev_oe, 1'b0)
      prom_programmer_model_inst.set_addr(11'h7ff);
      prom_programmer_model_inst.set_verify(1'b0);
      look();
      `CHK(dev_oe, 1'b1)
      `CHK(dev_out, 8'h00)
      prom_programmer_model_inst.set_verify(1'b1);
      look();
      `CHK(dev_oe, 1'b0)
      $display("test blank done");
   endtask : t_blank
   task automatic t_bytes();
      prom_programmer_model_inst.enter_prog();
      look();
      `CHK(dev_oe, 1'b0)
      prom_programmer_model_inst.pulse(11'h005, 1'b0, 8'ha5, 1);
      chk_verify(8'ha5);
      prom_programmer_model_inst.pulse(11'h005, 1'b0, 8'ha5, 1);
      prom_programmer_model_inst.pulse(11'h005, 1'b0, 8'h0f, 1);
      chk_verify(8'haf);
      prom_programmer_model_inst.exit_prog();
      prom_programmer_model_inst.set_verify(1'b0);
      prom_programmer_model_inst.set_addr(11'h005);
      prom_programmer_model_inst.set_addr(11'h000);
      look();
      `CHK(dev_out, 8'haf)
      look();
      `CHK(dev_out, 8'h00)
      prom_programmer_model_inst.set_verify(1'b1);
      $display("test bytes done");
   endtask : t_bytes
   task automatic t_gate();
      logic [31:0] rd;
      logic        err;
      apb(1'b1, prom_pkg::CTRL_OFS, 32'h0, rd, err);
      `CHK(err, 1'b0)
      apb(1'b0, 12'h008, 32'h0, rd, err);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h0)
      prom_programmer_model_inst.enter_prog();
      prom_programmer_model_inst.pulse(11'h006, 1'b0, 8'hff, 1);
      chk_verify(8'h00);
      prom_programmer_model_inst.exit_prog();
      apb(1'b1, prom_pkg::CTRL_OFS, 32'h1, rd, err);
      $display("test gate done");
   endtask : t_gate
   task automatic t_init();
      logic [31:0] rd;
      logic        err;
      prom_programmer_model_inst.set_init(1'b0);
      look();
      `CHK(dev_oe, 1'b0)
      `CHK(dev_out, 8'h00)
      prom_programmer_model_inst.set_verify(1'b0);
      look();
      `CHK(dev_oe, 1'b1)
      prom_programmer_model_inst.enter_prog();
      prom_programmer_model_inst.pulse(11'h000, 1'b1, 8'h3c, 1);
      prom_programmer_model_inst.exit_prog();
      prom_programmer_model_inst.set_addr(11'h005);
      prom_programmer_model_inst.set_verify(1'b0);
      prom_programmer_model_inst.set_init(1'b0);
      look();
      `CHK(dev_out, 8'h3c)
      tick(3);
      look();
      `CHK(dev_out, 8'h3c)
      prom_programmer_model_inst.set_init(1'b1);
      tick(2);
      look();
      `CHK(dev_out, 8'haf)
      prom_programmer_model_inst.enter_prog();
      prom_programmer_model_inst.pulse(11'h000, 1'b1, 8'hc3, 1);
      prom_programmer_model_inst.exit_prog();
      prom_programmer_model_inst.set_init(1'b0);
      look();
      `CHK(dev_out, 8'hff)
      prom_programmer_model_inst.set_init(1'b1);
      apb(1'b0, prom_pkg::STATUS_OFS, 32'h0, rd, err);
      `CHK(rd[15:8], 8'hff)
      $display("test init done");
   endtask : t_init
   task automatic t_sync();
      logic [31:0] rd;
      logic        err;
      prom_programmer_model_inst.enter_prog();
      prom_programmer_model_inst.pulse(11'h004, 1'b1, 8'h00, CELL_LEN + 2);
      prom_programmer_model_inst.exit_prog();
      prom_programmer_model_inst.set_addr(11'h005);
      do_reset();
      look();
      look();
      `CHK(dev_oe, 1'b0)
      apb(1'b0, prom_pkg::STATUS_OFS, 32'h0, rd, err);
      `CHK(rd[prom_pkg::ST_SYNC], 1'b1)
      prom_programmer_model_inst.set_verify(1'b0);
      look();
      `CHK(dev_oe, 1'b0)
      look();
      `CHK(dev_oe, 1'b1)
      `CHK(dev_out, 8'haf)
      prom_programmer_model_inst.set_verify(1'b1);
      look();
      `CHK(dev_oe, 1'b1)
      look();
      `CHK(dev_oe, 1'b0)
      $display("test sync done");
   endtask : t_sync
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      do_reset();
      tick(2);
      t_blank();
      t_bytes();
      t_gate();
      t_init();
      t_sync();
      conclude();
   end
   initial begin
      tick(5000);
      n_errors++;
      conclude();
   end
endmodule : registered_prom_readout_bench
